// *** dv/pder_host.sv ***
// host model: byte reads and writes on the register access port
`timescale 1ns/100ps
module pder_host (
    // clock
    input  wire logic ref_clk,
    // register access port
    output logic [7:0] reg_addr,
    output logic       reg_write,
    output logic [7:0] reg_wdata,
    output logic       reg_read
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
        reg_read = 1'b0;
    end
    // after the strobe, address and data are inverted so stale values never pass as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // pder_host

// *** dv/pder_regs_assertions.sv ***
// checker: port-level assertions for the pulse register bank
`timescale 1ns/100ps
module pder_regs_assertions (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // register access port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // samples and interrupt
    input wire logic       sample_valid,
    input wire logic       pulse_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire rd_src = reg_read && reg_addr == pder_pkg::ADDR_SOURCE;
    wire rd_thr = reg_read && reg_addr >= pder_pkg::ADDR_THRESH_X
                  && reg_addr <= pder_pkg::ADDR_THRESH_Z;
    wire rd_unm = reg_read && (reg_addr < pder_pkg::ADDR_CONFIG
                  || reg_addr > pder_pkg::ADDR_THRESH_Z);

    // ****************
    // sequences
    // ****************
    // an event lands two edges after its sample: no sample now or in the previous cycle
    sequence s_quiet_src;
        rd_src && !sample_valid && !$past(sample_valid);
    endsequence
    sequence s_wr_rd(logic [7:0] a);
        (reg_write && reg_addr == a) ##1 !reg_write ##1 (reg_read && reg_addr == a);
    endsequence

    // ****************
    // assertions
    // ****************
    a_src_read_clears: assert property (s_quiet_src ##1 !sample_valid ##1 rd_src
        |=> reg_rdata == pder_pkg::READ_ZERO) else $error("source not cleared by read");
    a_irq_drop_read: assert property (s_quiet_src |=> !pulse_irq)
        else $error("interrupt still high after source read");
    a_irq_mirror: assert property (rd_src |=> reg_rdata[7] == $past(pulse_irq))
        else $error("source bit 7 differs from interrupt");
    a_irq_sticky: assert property (pulse_irq && !rd_src |=> pulse_irq)
        else $error("interrupt dropped without source read");
    a_irq_cause: assert property ($rose(pulse_irq)
        |-> $past(sample_valid, 2) || $past(sample_valid, 3))
        else $error("interrupt rose without a sample");
    a_thr_bit_seven: assert property (rd_thr |=> !reg_rdata[7])
        else $error("threshold bit 7 reads one");
    a_unmapped_zero: assert property (rd_unm |=> reg_rdata == pder_pkg::READ_ZERO)
        else $error("unmapped read not zero");
    a_cfg_readback: assert property (s_wr_rd(pder_pkg::ADDR_CONFIG)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("config readback wrong");
    a_thr_readback: assert property (s_wr_rd(pder_pkg::ADDR_THRESH_X)
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7F)) else $error("threshold readback wrong");
endmodule // pder_regs_assertions

bind pder_regs pder_regs_assertions u_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .pulse_irq(pulse_irq)
);

// *** dv/pulse_detect_event_regs_test.sv ***
// self-checking bench for the pulse register bank
`timescale 1ns/100ps
module pulse_detect_event_regs_test;
    // ****************
    // stimulus and scoreboard
    // ****************
    logic              ref_clk = 1'b0;
    logic              rst = 1'b1;
    logic              sample_valid = 1'b0;
    logic signed [7:0] accel_x = 8'sh00;
    logic signed [7:0] accel_y = 8'sh00;
    logic signed [7:0] accel_z = 8'sh00;
    logic [7:0]        time_limit = 8'h03;
    logic [7:0]        latency = 8'h04;
    logic [7:0]        double_window = 8'h08;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, d;
    logic              reg_write, reg_read, pulse_irq;
    logic              rd_seen = 1'b0;
    logic [7:0]        exp_q[$];
    logic [7:0]        rw_addr[5] = '{8'h21, 8'h23, 8'h24, 8'h25, 8'h22};
    logic [7:0]        rw_mask[5] = '{8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h00};
    logic [7:0]        ev_cfg[4] = '{8'h01, 8'h04, 8'h10, 8'h02};
    logic [7:0]        ev_x[4] = '{8'h0A, 8'h00, 8'h00, 8'h0A};
    logic [7:0]        ev_y[4] = '{8'h00, 8'hF6, 8'h00, 8'h00};
    logic [7:0]        ev_z[4] = '{8'h00, 8'h00, 8'hF6, 8'h00};
    logic [7:0]        ev_exp[4] = '{8'h90, 8'hA2, 8'hC4, 8'h00};
    logic [7:0]        dbl_cfg[4] = '{8'h02, 8'h82, 8'h08, 8'h20};
    logic [23:0]       dbl_p[4] = '{24'h0A0000, 24'h0A0000, 24'h00F600, 24'h00000A};
    logic [7:0]        dbl_exp[4] = '{8'h98, 8'h00, 8'hAA, 8'hC8};
    int                errors = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    int                seed = 33;

    always #4 ref_clk = ~ref_clk;

    pder_regs u_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .accel_x(accel_x), .accel_y(accel_y),
        .accel_z(accel_z), .time_limit(time_limit), .latency_timer_setting(latency),
        .double_window(double_window), .pulse_irq(pulse_irq)
    );
    pder_host u_host (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_read(reg_read)
    );

    // ****************
    // tasks
    // ****************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_irq(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    // one sample per two cycles; between samples the axes carry inverted junk
    task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        {accel_x, accel_y, accel_z} <= {x, y, z};
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        {accel_x, accel_y, accel_z} <= ~{x, y, z};
    endtask
    task automatic quiet(input int n);
        repeat (n) smp(8'h00, 8'h00, 8'h00);
    endtask
    // host services the event, then reads twice more to see the clear; long idle after
    task automatic src(input logic [7:0] e);
        quiet(3);
        check_irq(pulse_irq, e[7]);
        rd(8'h22, e);
        rd(8'h22, 8'h00);
        rd(8'h22, 8'h00);
        check_irq(pulse_irq, 1'b0);
        quiet(16);
    endtask

    // ****************
    // result watcher and hang limit
    // ****************
    always @(posedge ref_clk) begin
        cycles++;
        if (rd_seen && exp_q.size() > 0) begin
            check(reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_read;
        if (cycles == 40000) begin
            errors++;
            results;
        end
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rw_addr[i]) rd(rw_addr[i], 8'h00);
        rd(8'h20, 8'h00);
        foreach (rw_addr[i]) begin
            d = 8'($random(seed));
            u_host.wr(rw_addr[i], d);
            rd(rw_addr[i], d & rw_mask[i]);
        end
        u_host.wr(8'h23, 8'h04);
        u_host.wr(8'h24, 8'h04);
        u_host.wr(8'h25, 8'h04);
        foreach (ev_cfg[i]) begin
            u_host.wr(8'h21, ev_cfg[i]);
            smp(ev_x[i], ev_y[i], ev_z[i]);
            src(ev_exp[i]);
        end
        // second pulse inside latency, then one in the window; x, x with abort, y, z
        for (int a = 0; a < 4; a++) begin
            u_host.wr(8'h21, dbl_cfg[a]);
            smp(dbl_p[a][23:16], dbl_p[a][15:8], dbl_p[a][7:0]);
            quiet(1);
            smp(dbl_p[a][23:16], dbl_p[a][15:8], dbl_p[a][7:0]);
            quiet(5);
            smp(dbl_p[a][23:16], dbl_p[a][15:8], dbl_p[a][7:0]);
            src(dbl_exp[a]);
        end
        for (int l = 0; l < 2; l++) begin
            u_host.wr(8'h21, {1'b0, l[0], 6'h05});
            smp(8'h0A, 8'h00, 8'h00);
            smp(8'h00, 8'hF6, 8'h00);
            src(l == 1 ? 8'h90 : 8'hA2);
        end
        u_host.wr(8'h23, 8'h14);
        u_host.wr(8'h21, 8'h01);
        repeat (12) smp(8'($random(seed) % 21), 8'h00, 8'h00);
        src(8'h00);
        smp(8'(21 + ($random(seed) & 63)), 8'h00, 8'h00);
        src(8'h90);
        results;
    end
endmodule // pulse_detect_event_regs_test

// *** rtl/pder_axis.sv ***
// per-axis single and double pulse detector
`timescale 1ns/100ps
module pder_axis #(
    parameter int SAMPLE_W = 8
) (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // samples, one per output data period
    input  wire logic                           sample_valid,
    input  wire logic signed [SAMPLE_W-1:0]     sample,
    // settings
    input  wire logic [pder_pkg::THRESH_W-1:0]  threshold,
    input  wire logic [7:0]                     time_limit,
    input  wire logic [7:0]                     latency,
    input  wire logic [7:0]                     window,
    input  wire logic                           abort_option,
    // results
    output logic                                single_evt,
    output logic                                double_evt,
    output logic                                polarity
);

    if (SAMPLE_W <= pder_pkg::THRESH_W) begin : g_bad_width
        $error("pder_axis: sample narrower than threshold");
    end

    typedef struct packed {
        pder_pkg::pder_axis_state_t state;
        logic [7:0]                 cnt;
        logic                       sign;
        logic                       stale;
        logic                       seen_hi;
        logic                       aborted;
        logic                       single_evt;
        logic                       double_evt;
        logic                       polarity;
    } pder_axis_regs_t;

    pder_axis_regs_t             r;
    pder_axis_regs_t             next_r;
    logic [SAMPLE_W-1:0]         mag;
    logic                        above;

    // unsigned magnitude; one step of threshold equals one sample lsb
    assign mag   = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : SAMPLE_W'(sample);
    assign above = mag > SAMPLE_W'(threshold);

    always_comb begin
        next_r            = r;
        next_r.single_evt = 1'b0;
        next_r.double_evt = 1'b0;
        if (sample_valid) begin
            if (!above) begin
                next_r.stale = 1'b0;
            end
            unique case (r.state)
                pder_pkg::PDER_IDLE: begin
                    if (above && !r.stale) begin
                        next_r.state = pder_pkg::PDER_FIRST;
                        next_r.cnt   = 8'h00;
                        next_r.sign  = sample[SAMPLE_W-1];
                    end
                end
                pder_pkg::PDER_FIRST: begin
                    if (!above) begin
                        next_r.single_evt = 1'b1;
                        next_r.polarity   = r.sign;
                        next_r.state      = pder_pkg::PDER_LATENCY;
                        next_r.cnt        = 8'h00;
                        next_r.seen_hi    = 1'b0;
                        next_r.aborted    = 1'b0;
                    end else if (r.cnt >= time_limit) begin
                        // too long to be a pulse: wait for the level to drop
                        next_r.state = pder_pkg::PDER_IDLE;
                        next_r.stale = 1'b1;
                    end else begin
                        next_r.cnt = r.cnt + 8'h01;
                    end
                end
                pder_pkg::PDER_LATENCY: begin
                    // pulses here never raise an event
                    if (above) begin
                        next_r.seen_hi = 1'b1;
                    end else if (r.seen_hi && abort_option) begin
                        next_r.aborted = 1'b1;
                    end
                    if (r.cnt >= latency) begin
                        // without abort option a pulse here is simply ignored
                        next_r.state = next_r.aborted ? pder_pkg::PDER_IDLE
                                                      : pder_pkg::PDER_WINDOW;
                        next_r.stale = above;
                        next_r.cnt   = 8'h00;
                    end else begin
                        next_r.cnt = r.cnt + 8'h01;
                    end
                end
                pder_pkg::PDER_WINDOW: begin
                    if (above && !r.stale) begin
                        next_r.state = pder_pkg::PDER_SECOND;
                        next_r.cnt   = 8'h00;
                        next_r.sign  = sample[SAMPLE_W-1];
                    end else if (r.cnt >= window) begin
                        next_r.state = pder_pkg::PDER_IDLE;
                    end else begin
                        next_r.cnt = r.cnt + 8'h01;
                    end
                end
                pder_pkg::PDER_SECOND: begin
                    if (!above) begin
                        next_r.double_evt = 1'b1;
                        next_r.polarity   = r.sign;
                        next_r.state      = pder_pkg::PDER_IDLE;
                    end else if (r.cnt >= time_limit) begin
                        next_r.state = pder_pkg::PDER_IDLE;
                        next_r.stale = 1'b1;
                    end else begin
                        next_r.cnt = r.cnt + 8'h01;
                    end
                end
                default: begin
                    next_r.state = pder_pkg::PDER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r       <= '0;
            r.state <= pder_pkg::PDER_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign single_evt = r.single_evt;
    assign double_evt = r.double_evt;
    assign polarity   = r.polarity;

endmodule // pder_axis

// *** rtl/pder_pkg.sv ***
// package of constants and types for the pulse detection event registers
package pder_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_CONFIG   = 8'h21;
    localparam logic [7:0] ADDR_SOURCE   = 8'h22;
    localparam logic [7:0] ADDR_THRESH_X = 8'h23;
    localparam logic [7:0] ADDR_THRESH_Y = 8'h24;
    localparam logic [7:0] ADDR_THRESH_Z = 8'h25;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         NUM_AXES          = 3;
    localparam int         CFG_ABORT_BIT     = 7;
    localparam int         CFG_LATCH_BIT     = 6;
    localparam int         SRC_ACTIVE_BIT    = 7;
    localparam int         SRC_AXIS_LSB      = 4;
    localparam int         SRC_DOUBLE_BIT    = 3;
    localparam int         SRC_POL_LSB       = 0;
    localparam int         THRESH_W          = 7;
    localparam logic [7:0] CONFIG_RESET      = 8'h00;
    localparam logic [6:0] THRESH_RESET      = 7'h00;
    localparam logic [7:0] READ_ZERO         = 8'h00;
    // threshold scale: milli-g per step and fixed full range in g
    localparam int         THRESH_STEP_MILLI_G = 63;
    localparam int         THRESH_RANGE_G      = 8;

    // ************************************************************
    // per-axis detector states
    // ************************************************************
    typedef enum logic [4:0] {
        PDER_IDLE    = 5'h01,
        PDER_FIRST   = 5'h02,
        PDER_LATENCY = 5'h04,
        PDER_WINDOW  = 5'h08,
        PDER_SECOND  = 5'h10
    } pder_axis_state_t;

endpackage

// *** rtl/pder_regs.sv ***
// pulse detection configuration, source and threshold register bank
`timescale 1ns/100ps
module pder_regs #(
    parameter int SAMPLE_W = 8
) (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // register access port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_write,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_read,
    output logic [7:0]                      reg_rdata,
    // acceleration samples
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] accel_x,
    input  wire logic signed [SAMPLE_W-1:0] accel_y,
    input  wire logic signed [SAMPLE_W-1:0] accel_z,
    // timer settings, in sample periods
    input  wire logic [7:0]                 time_limit,
    input  wire logic [7:0]                 latency_timer_setting,
    input  wire logic [7:0]                 double_window,
    // interrupt
    output logic                            pulse_irq
);

    if (SAMPLE_W < 8 || SAMPLE_W > 16) begin : g_bad_width
        $error("pder_regs: SAMPLE_W must be 8 to 16");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]                                    config_reg;
        logic [7:0]                                    source;
        logic [pder_pkg::NUM_AXES-1:0][pder_pkg::THRESH_W-1:0] thresh;
        logic [7:0]                                    rdata;
        logic                                          irq;
    } pder_regs_state_t;

    pder_regs_state_t                                   r;
    pder_regs_state_t                                   next_r;
    logic signed [pder_pkg::NUM_AXES-1:0][SAMPLE_W-1:0] accel;
    logic [pder_pkg::NUM_AXES-1:0]                      single_evt;
    logic [pder_pkg::NUM_AXES-1:0]                      double_evt;
    logic [pder_pkg::NUM_AXES-1:0]                      pol_evt;
    logic [pder_pkg::NUM_AXES-1:0]                      single_hit;
    logic [pder_pkg::NUM_AXES-1:0]                      double_hit;
    logic [pder_pkg::NUM_AXES-1:0]                      hit;
    logic [4:0]                                         wr_sel;
    logic [4:0]                                         rd_sel;

    // one-hot decode: config, source, threshold x, y, z
    function automatic logic [4:0] reg_decode(input logic [7:0] addr);
        logic [4:0] sel;
        sel = 5'h00;
        unique case (addr)
            pder_pkg::ADDR_CONFIG:   sel = 5'h01;
            pder_pkg::ADDR_SOURCE:   sel = 5'h02;
            pder_pkg::ADDR_THRESH_X: sel = 5'h04;
            pder_pkg::ADDR_THRESH_Y: sel = 5'h08;
            pder_pkg::ADDR_THRESH_Z: sel = 5'h10;
            default:                 sel = 5'h00;
        endcase
        return sel;
    endfunction

    assign wr_sel = reg_write ? reg_decode(reg_addr) : 5'h00;
    assign rd_sel = reg_read  ? reg_decode(reg_addr) : 5'h00;

    assign accel[0] = accel_x;
    assign accel[1] = accel_y;
    assign accel[2] = accel_z;

    // ************************************************************
    // per-axis detectors
    // ************************************************************
    for (genvar a = 0; a < pder_pkg::NUM_AXES; a++) begin : g_axis
        pder_axis #(
            .SAMPLE_W (SAMPLE_W)
        ) u_axis (
            .ref_clk      (ref_clk),
            .rst          (rst),
            .sample_valid (sample_valid),
            .sample       (accel[a]),
            .threshold    (r.thresh[a]),
            .time_limit   (time_limit),
            .latency      (latency_timer_setting),
            .window       (double_window),
            .abort_option (r.config_reg[pder_pkg::CFG_ABORT_BIT]),
            .single_evt   (single_evt[a]),
            .double_evt   (double_evt[a]),
            .polarity     (pol_evt[a])
        );
        // even bit enables single, odd bit double, per axis
        assign single_hit[a] = single_evt[a] & r.config_reg[2*a];
        assign double_hit[a] = double_evt[a] & r.config_reg[2*a+1];
        assign hit[a]        = single_hit[a] | double_hit[a];
    end

    // ************************************************************
    // register update
    // ************************************************************
    always_comb begin
        logic                          latch_on;
        logic [pder_pkg::NUM_AXES-1:0] pol_now;
        latch_on = r.config_reg[pder_pkg::CFG_LATCH_BIT];
        pol_now  = r.source[pder_pkg::SRC_POL_LSB +: pder_pkg::NUM_AXES];
        next_r   = r;

        if (wr_sel[0]) begin
            next_r.config_reg = reg_wdata;
        end
        for (int a = 0; a < pder_pkg::NUM_AXES; a++) begin
            if (wr_sel[2+a]) begin
                next_r.thresh[a] = reg_wdata[pder_pkg::THRESH_W-1:0];
            end
        end

        // read data shows the value before any clear in this cycle
        if (rd_sel[0]) begin
            next_r.rdata = r.config_reg;
        end else if (rd_sel[1]) begin
            next_r.rdata = r.source;
        end else if (|rd_sel[4:2]) begin
            next_r.rdata = pder_pkg::READ_ZERO;
            for (int a = 0; a < pder_pkg::NUM_AXES; a++) begin
                if (rd_sel[2+a]) begin
                    next_r.rdata = {1'b0, r.thresh[a]};
                end
            end
        end else if (reg_read) begin
            next_r.rdata = pder_pkg::READ_ZERO;
        end

        // source read clears the whole source register; an event in the same cycle still lands
        if (rd_sel[1]) begin
            next_r.source = pder_pkg::READ_ZERO;
            pol_now       = '0;
        end

        if (|hit) begin
            if (next_r.source[pder_pkg::SRC_ACTIVE_BIT] && latch_on) begin
                // held until the host reads the source register
                next_r.source = next_r.source;
            end else begin
                for (int a = 0; a < pder_pkg::NUM_AXES; a++) begin
                    if (hit[a]) begin
                        pol_now[a] = pol_evt[a];
                    end
                end
                // latching off or no event held yet: active, axis and double bits track the newest result; axes without a hit keep their polarity bits
                next_r.source[pder_pkg::SRC_ACTIVE_BIT] = 1'b1;
                next_r.source[pder_pkg::SRC_AXIS_LSB +: pder_pkg::NUM_AXES] = hit;
                next_r.source[pder_pkg::SRC_DOUBLE_BIT] = |double_hit;
                next_r.source[pder_pkg::SRC_POL_LSB +: pder_pkg::NUM_AXES] = pol_now;
            end
        end

        // interrupt follows the active flag, so a source read drops it
        next_r.irq = next_r.source[pder_pkg::SRC_ACTIVE_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r            <= '0;
            r.config_reg <= pder_pkg::CONFIG_RESET;
            r.thresh     <= {pder_pkg::NUM_AXES{pder_pkg::THRESH_RESET}};
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign pulse_irq = r.irq;

endmodule // pder_regs
